// >>> inc/cfd_pkg.sv
// shared constants and types of the clock fanout half rate driver
package cfd_pkg;

  // ----------------------------------------------------------------
  // output group sizes
  // ----------------------------------------------------------------
  localparam int unsigned FULL_RATE_COUNT = 4;
  localparam int unsigned HALF_RATE_COUNT = 4;

  // ----------------------------------------------------------------
  // input synchroniser
  // ----------------------------------------------------------------
  localparam int unsigned SYNC_STAGES = 3;

  // ----------------------------------------------------------------
  // pin bundle and reset values
  // ----------------------------------------------------------------
  typedef struct packed {
    logic src_clk;
    logic divider_reset_n;
    logic drive_enable_n;
  } cfd_pins_t;

  localparam int unsigned PIN_COUNT = $bits(cfd_pins_t);

  // clock low, divider held clear, outputs floating
  localparam cfd_pins_t PINS_RST = '{
    src_clk: 1'h0,
    divider_reset_n: 1'h0,
    drive_enable_n: 1'h1
  };

  localparam logic TOGGLE_RST = 1'h0;
  localparam logic OUT_RST = 1'h0;
  localparam logic OE_N_RST = 1'h1;

endpackage : cfd_pkg

// >>> logic/cfd_driver.sv
// clock fanout driver with full rate and half rate output groups
//
// How it works
// - eight outputs, four full, four half rate
// - full rate outputs follow input clock level
// - half rate outputs invert on clock rise
// - half rate period spans two input periods
// - clear low forces half rate outputs low
// - enable high floats all eight outputs
// - no rise, half rate outputs hold level
`timescale 1ns/100ps
module cfd_driver #(
  parameter int unsigned FULL_N = cfd_pkg::FULL_RATE_COUNT,
  parameter int unsigned HALF_N = cfd_pkg::HALF_RATE_COUNT
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic src_clk_in,
  input wire logic divider_reset_n_in,
  input wire logic drive_enable_n_in,
  output logic [FULL_N-1:0] full_rate_outputs_out,
  output logic [FULL_N-1:0] full_rate_oe_n_out,
  output logic [HALF_N-1:0] half_rate_outputs_out,
  output logic [HALF_N-1:0] half_rate_oe_n_out
);

  // ----------------------------------------------------------------
  // pin bundle
  // ----------------------------------------------------------------
  cfd_pkg::cfd_pins_t pins_raw;

  assign pins_raw.src_clk = src_clk_in;
  assign pins_raw.divider_reset_n = divider_reset_n_in;
  assign pins_raw.drive_enable_n = drive_enable_n_in;

  // ----------------------------------------------------------------
  // pin synchroniser, three stages
  // ----------------------------------------------------------------
  cfd_pkg::cfd_pins_t sync1_ff;
  cfd_pkg::cfd_pins_t sync2_ff;
  cfd_pkg::cfd_pins_t sync3_ff;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sync1_ff <= cfd_pkg::PINS_RST;
    end else begin
      sync1_ff <= pins_raw;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sync2_ff <= cfd_pkg::PINS_RST;
    end else begin
      sync2_ff <= sync1_ff;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sync3_ff <= cfd_pkg::PINS_RST;
    end else begin
      sync3_ff <= sync2_ff;
    end
  end

  // ----------------------------------------------------------------
  // stage agreement filter
  // ----------------------------------------------------------------
  cfd_pkg::cfd_pins_t pins_ff;
  cfd_pkg::cfd_pins_t nxt_pins;
  wire logic [cfd_pkg::PIN_COUNT-1:0] stages_agree;

  // a bit takes its new level once stages two and three agree
  genvar p;
  generate
    for (p = 0; p < cfd_pkg::PIN_COUNT; p++) begin : g_filt
      assign stages_agree[p] = (sync2_ff[p] == sync3_ff[p]);
      assign nxt_pins[p] = stages_agree[p] ? sync3_ff[p] : pins_ff[p];
    end
  endgenerate

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pins_ff <= cfd_pkg::PINS_RST;
    end else begin
      pins_ff <= nxt_pins;
    end
  end

  // ----------------------------------------------------------------
  // clock edge and clear decode
  // ----------------------------------------------------------------
  wire logic clk_rise;
  wire logic clear_active;

  assign clk_rise = nxt_pins.src_clk & ~pins_ff.src_clk;
  assign clear_active = ~nxt_pins.divider_reset_n;

  // ----------------------------------------------------------------
  // half rate toggle
  // ----------------------------------------------------------------
  logic toggle_ff;
  logic nxt_toggle;
  wire logic toggle_run;

  // one flip per rise halves rate
  assign toggle_run = clk_rise ? ~toggle_ff : toggle_ff;

  assign nxt_toggle = clear_active ? cfd_pkg::TOGGLE_RST : toggle_run;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      toggle_ff <= cfd_pkg::TOGGLE_RST;
    end else begin
      toggle_ff <= nxt_toggle;
    end
  end

  // ----------------------------------------------------------------
  // drive enable decode
  // ----------------------------------------------------------------
  wire logic float_all;

  assign float_all = pins_ff.drive_enable_n;

  // ----------------------------------------------------------------
  // output levels
  // ----------------------------------------------------------------
  wire logic full_level;
  wire logic half_level;
  wire logic [FULL_N-1:0] nxt_full;
  wire logic [FULL_N-1:0] nxt_full_oe_n;
  wire logic [HALF_N-1:0] nxt_half;
  wire logic [HALF_N-1:0] nxt_half_oe_n;

  assign full_level = pins_ff.src_clk & ~float_all;

  assign half_level = toggle_ff & ~float_all;

  // ----------------------------------------------------------------
  // full rate group
  // ----------------------------------------------------------------
  // four full rate outputs
  genvar f;
  generate
    for (f = 0; f < FULL_N; f++) begin : g_full_next
      assign nxt_full[f] = full_level;
    end
  endgenerate

  genvar fo;
  generate
    for (fo = 0; fo < FULL_N; fo++) begin : g_full_oe
      assign nxt_full_oe_n[fo] = float_all;
    end
  endgenerate

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      full_rate_outputs_out <= {FULL_N{cfd_pkg::OUT_RST}};
    end else begin
      full_rate_outputs_out <= nxt_full;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      full_rate_oe_n_out <= {FULL_N{cfd_pkg::OE_N_RST}};
    end else begin
      full_rate_oe_n_out <= nxt_full_oe_n;
    end
  end

  // ----------------------------------------------------------------
  // half rate group
  // ----------------------------------------------------------------
  // four half rate outputs
  genvar h;
  generate
    for (h = 0; h < HALF_N; h++) begin : g_half_next
      assign nxt_half[h] = half_level;
    end
  endgenerate

  genvar ho;
  generate
    for (ho = 0; ho < HALF_N; ho++) begin : g_half_oe
      assign nxt_half_oe_n[ho] = float_all;
    end
  endgenerate

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      half_rate_outputs_out <= {HALF_N{cfd_pkg::OUT_RST}};
    end else begin
      half_rate_outputs_out <= nxt_half;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      half_rate_oe_n_out <= {HALF_N{cfd_pkg::OE_N_RST}};
    end else begin
      half_rate_oe_n_out <= nxt_half_oe_n;
    end
  end

endmodule : cfd_driver

// >>> verification/cfd_src_model.sv
// clock source model, stands low between bursts
`timescale 1ns/100ps
module cfd_src_model (
  input wire logic clk_in,
  input wire logic run_in,
  output logic src_out
);
  logic [2:0] cnt_ff = 3'h0;
  // four cycles per phase while running
  always @(negedge clk_in) cnt_ff <= run_in ? cnt_ff + 3'h1 : 3'h0;
  assign src_out = cnt_ff[2];
endmodule : cfd_src_model

// >>> verification/cfd_monitor.sv
// checker of the clock fanout driver
`timescale 1ns/100ps
module cfd_monitor (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic src_clk_in,
  input wire logic divider_reset_n_in,
  input wire logic drive_enable_n_in,
  input wire logic [3:0] full_rate_outputs_out,
  input wire logic [3:0] full_rate_oe_n_out,
  input wire logic [3:0] half_rate_outputs_out,
  input wire logic [3:0] half_rate_oe_n_out
);
  wire [3:0] f = full_rate_outputs_out;
  wire [3:0] h = half_rate_outputs_out;
  wire [7:0] oe = {full_rate_oe_n_out, half_rate_oe_n_out};
  wire s = src_clk_in;
  wire c = divider_reset_n_in;
  wire d = drive_enable_n_in;
  logic [2:0] age_ff;
  wire ok = &age_ff;
  always_ff @(posedge clk_in) age_ff <= rst_in ? 3'h0 : age_ff + 3'(!ok);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  chk_full_follow: assert property (ok |->
    f == {4{$past(s, 5) && !$past(d, 5)}}) else $error("full level");
  chk_oe_follow: assert property (ok |-> oe == {8{$past(d, 5)}})
    else $error("enable");
  chk_float_zero: assert property (ok && $past(d, 5) |-> h == 0)
    else $error("float");
  chk_clear_low: assert property (ok && !$past(c, 5) |-> h == 0)
    else $error("clear");
  chk_toggle_rise: assert property (ok && !$past(d, 6) && !$past(d, 5)
    && $past(c, 5) && $rose(f[0]) |-> h == ~$past(h)) else $error("toggle");
  chk_hold_level: assert property (ok && !$past(d, 6) && !$past(d, 5)
    && $past(c, 5) && !$rose(f[0]) |-> $stable(h)) else $error("hold");
  chk_same_level: assert property (
    (f == 0 || &f) && (h == 0 || &h)) else $error("group");
  chk_half_rate: assert property (ok && !$past(d, 6) && !$past(d, 5)
    && $rose(h[0]) |-> $rose(f[0])) else $error("rate");
  cover property (ok && $rose(h[0]));
  cover property (ok && $fell(h[0]) && c);
  cover property (ok && &oe);
endmodule : cfd_monitor
bind cfd_driver cfd_monitor cfd_monitor_i(.*);

// >>> verification/test_cfd_driver.sv
// bench of the clock fanout driver
`timescale 1ns/100ps
module test_cfd_driver;
  logic clk_in = 1'h0;
  logic rst_in = 1'h1;
  logic run = 1'h0;
  logic divider_reset_n_in = 1'h0;
  logic drive_enable_n_in = 1'h1;
  logic src_clk_in;
  logic [3:0] full_rate_outputs_out, full_rate_oe_n_out;
  logic [3:0] half_rate_outputs_out, half_rate_oe_n_out;
  int failures = 0;
  int checks_done = 0;
  // enable_n, clear_n, rise count, half level
  logic [4:0] rows [8] = '{5'h04, 5'h0b, 5'h0d, 5'h1c,
    5'h09, 5'h0a, 5'h0f, 5'h00};
  cfd_driver cfd_driver_i(.*);
  cfd_src_model cfd_src_model_i(.clk_in, .run_in(run), .src_out(src_clk_in));
  always #20 clk_in = ~clk_in;
  task automatic chk(input string nm, input logic [3:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic give_verdict;
    if (failures == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : give_verdict
  initial begin
    #20000;
    failures++;
    give_verdict;
  end
  initial begin
    repeat (3) @(negedge clk_in);
    rst_in = 1'h0;
    foreach (rows[i]) begin
      {drive_enable_n_in, divider_reset_n_in} = rows[i][4:3];
      if (rows[i][2:1] != 2'h0) begin
        run = 1'h1;
        repeat (8 * rows[i][2:1]) @(negedge clk_in);
        run = 1'h0;
      end
      repeat (8) @(negedge clk_in);
      chk("half", half_rate_outputs_out, {4{rows[i][0]}});
      chk("full oe", full_rate_oe_n_out, {4{rows[i][4]}});
      chk("half oe", half_rate_oe_n_out, {4{rows[i][4]}});
      chk("full low", full_rate_outputs_out, 4'h0);
    end
    run = 1'h1;
    repeat (10) @(negedge clk_in);
    chk("full", full_rate_outputs_out, 4'hf);
    rst_in = 1'h1;
    @(negedge clk_in);
    chk("reset full oe", full_rate_oe_n_out, 4'hf);
    chk("reset half oe", half_rate_oe_n_out, 4'hf);
    chk("reset full", full_rate_outputs_out, 4'h0);
    chk("reset half", half_rate_outputs_out, 4'h0);
    give_verdict;
  end
endmodule : test_cfd_driver
